// File: design/imcs_pkg.sv
// constants and types shared by the bus master cycle sequencer
package imcs_pkg;

  // core clock and bus clock; the bus clock period is a plain default
  localparam int unsigned CLK_PERIOD_NS  = 5;
  localparam int unsigned BCLK_PERIOD_NS = 125;
  localparam int unsigned BCLK_CYC       = (BCLK_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned DIV_W          = 8;
  localparam logic [7:0]  DIV_LAST       = 8'(BCLK_CYC - 1);
  localparam logic [7:0]  DIV_ZERO       = 8'h00;

  // spacings in bus clock periods, all minimums
  localparam int unsigned LA_TO_ALE_NEG_T  = 5;
  localparam int unsigned SA_TO_ALE_NEG_T  = 1;
  localparam int unsigned LA_TO_CMD_T      = 5;
  localparam int unsigned SA_TO_CMD_T      = 2;
  localparam int unsigned ALE_WIDTH_T      = 1;
  localparam int unsigned ALE_TO_CMD_T     = 2;
  localparam int unsigned ALE_TO_CMD_NEG_T = 11;
  localparam int unsigned ALE_NEG_TO_LA_T  = 14;
  localparam int unsigned CMD_WIDTH_T      = 9;
  localparam int unsigned CMD_TO_LA_T      = 13;
  localparam int unsigned CMD_TO_SA_MEM_T  = 10;
  localparam int unsigned CMD_TO_SA_IO_T   = 19;

  // phase lengths derived from the spacings above
  localparam int unsigned TMR_W        = 5;
  localparam logic [4:0]  ADDR_PHASE_T = 5'(LA_TO_ALE_NEG_T - ALE_WIDTH_T);
  localparam logic [4:0]  ALE_PHASE_T  = 5'(ALE_WIDTH_T);
  localparam logic [4:0]  GAP_PHASE_T  = 5'(ALE_TO_CMD_T - ALE_WIDTH_T);
  localparam logic [4:0]  CMD_PHASE_T  = 5'(CMD_WIDTH_T);
  localparam logic [4:0]  HOLD_MEM_T   = 5'(CMD_TO_LA_T - CMD_WIDTH_T);
  localparam logic [4:0]  HOLD_IO_T    = 5'(CMD_TO_SA_IO_T - CMD_WIDTH_T);
  localparam logic [4:0]  TMR_ZERO     = 5'h00;
  localparam logic [4:0]  TMR_ONE      = 5'h01;

  // age counters used only by the checks
  localparam logic [4:0]  AGE_MAX = 5'h1f;
  localparam logic [4:0]  AGE_ONE = 5'h01;

  // address fields of a request
  localparam int unsigned ADDR_W  = 24;
  localparam int unsigned LA_HI   = 23;
  localparam int unsigned LA_LO   = 17;
  localparam int unsigned SA_HI   = 19;

  typedef enum logic [1:0] {
    KIND_MEM,
    KIND_LOWMEM,
    KIND_IO
  } imcs_kind_type;

endpackage

// File: design/imcs_bclk_div.sv
// bus clock tick generator: one core-clock pulse per bus clock period
`timescale 1ns/1ps
`default_nettype none
module imcs_bclk_div (
  input  wire logic clock,
  input  wire logic rstn,
  input  wire logic ce,
  output logic      tick
);
  logic [imcs_pkg::DIV_W-1:0] cnt;
  logic [imcs_pkg::DIV_W-1:0] next_cnt;

  // free running count, frozen while the clock enable is low
  always_comb begin
    next_cnt = cnt;
    if (ce) begin
      if (cnt == imcs_pkg::DIV_ZERO) begin
        next_cnt = imcs_pkg::DIV_LAST;
      end else begin
        next_cnt = cnt - 8'h01;
      end
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      cnt <= imcs_pkg::DIV_ZERO;
    end else begin
      cnt <= next_cnt;
    end
  end

  assign tick = ce && (cnt == imcs_pkg::DIV_ZERO);
endmodule
`default_nettype wire

// File: design/imcs_phase_timer.sv
// phase timer counting bus clock ticks down from a loaded length
`timescale 1ns/1ps
`default_nettype none
module imcs_phase_timer (
  input  wire logic                      clock,
  input  wire logic                      rstn,
  input  wire logic                      ce,
  input  wire logic                      tick,
  input  wire logic                      load,
  input  wire logic [imcs_pkg::TMR_W-1:0] load_val,
  output logic                           last
);
  logic [imcs_pkg::TMR_W-1:0] cnt;
  logic [imcs_pkg::TMR_W-1:0] next_cnt;

  // a load wins over the decrement, as it lands on the ending tick
  always_comb begin
    next_cnt = cnt;
    if (ce) begin
      if (load) begin
        next_cnt = load_val;
      end else if (tick && (cnt != imcs_pkg::TMR_ZERO)) begin
        next_cnt = cnt - imcs_pkg::TMR_ONE;
      end
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      cnt <= imcs_pkg::TMR_ZERO;
    end else begin
      cnt <= next_cnt;
    end
  end

  assign last = tick && (cnt == imcs_pkg::TMR_ONE);
endmodule
`default_nettype wire

// File: design/imcs_sequencer.sv
// bus master cycle sequencer: address, latch strobe and command ordering
`timescale 1ns/1ps
`default_nettype none
module imcs_sequencer (
  input  wire logic        CLOCK,
  input  wire logic        RSTN,
  input  wire logic        CE,
  input  wire logic        REQ_VALID,
  output logic             REQ_READY,
  input  wire logic [1:0]  REQ_KIND,
  input  wire logic        REQ_WRITE,
  input  wire logic [23:0] REQ_ADDR,
  input  wire logic        REQ_BHE,
  output logic             DONE,
  output logic [6:0]       LA,
  output logic [19:0]      SA,
  output logic             SBHE,
  output logic             ALE_N,
  output logic             MEMR_N,
  output logic             MEMW_N,
  output logic             SMEMR_N,
  output logic             SMEMW_N,
  output logic             IOR_N,
  output logic             IOW_N
);
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_ADDR,
    ST_ALE,
    ST_GAP,
    ST_CMD,
    ST_HOLD
  } imcs_state_type;

  imcs_state_type          state;
  imcs_state_type          next_state;
  imcs_pkg::imcs_kind_type kind;
  imcs_pkg::imcs_kind_type next_kind;
  logic                    write;
  logic                    next_write;
  logic [6:0]              next_la;
  logic [19:0]             next_sa;
  logic                    next_sbhe;
  logic                    next_ale_n;
  logic [5:0]              cmd_n;
  logic [5:0]              next_cmd_n;
  logic                    next_done;
  logic                    tick;
  logic                    last;
  logic                    load;
  logic [4:0]              load_val;
  logic                    accept;

  // all phases are counted in bus clock ticks
  imcs_bclk_div u_div (
    .clock (CLOCK),
    .rstn  (RSTN),
    .ce    (CE),
    .tick  (tick)
  );

  imcs_phase_timer u_tmr (
    .clock    (CLOCK),
    .rstn     (RSTN),
    .ce       (CE),
    .tick     (tick),
    .load     (load),
    .load_val (load_val),
    .last     (last)
  );

  // requests are taken only on a tick so every phase spans whole bus clocks
  assign REQ_READY = (state == ST_IDLE) && tick;
  assign accept    = REQ_VALID && REQ_READY;

  // one-hot-low command vector: memr, memw, smemr, smemw, ior, iow
  function automatic logic [5:0] cmd_vec(input imcs_pkg::imcs_kind_type k, input logic wr);
    logic [5:0] v;
    v = 6'h3f;
    if (k == imcs_pkg::KIND_MEM) begin
      v[wr ? 4 : 5] = 1'b0;
    end else if (k == imcs_pkg::KIND_LOWMEM) begin
      v[wr ? 2 : 3] = 1'b0;
    end else begin
      v[wr ? 0 : 1] = 1'b0;
    end
    return v;
  endfunction

  // sequencing: address, latch, gap, command, hold
  always_comb begin
    next_state = state;
    next_kind  = kind;
    next_write = write;
    next_la    = LA;
    next_sa    = SA;
    next_sbhe  = SBHE;
    next_done  = 1'b0;
    load       = 1'b0;
    load_val   = imcs_pkg::TMR_ZERO;
    case (state)
      ST_IDLE: begin
        if (accept) begin
          // addresses go out first and stay put until the next request
          // the unused kind code runs as i/o, so it also gets the long address hold
          next_kind  = (REQ_KIND == 2'h3) ? imcs_pkg::KIND_IO : imcs_pkg::imcs_kind_type'(REQ_KIND);
          next_write = REQ_WRITE;
          next_la    = REQ_ADDR[imcs_pkg::LA_HI:imcs_pkg::LA_LO];
          next_sa    = REQ_ADDR[imcs_pkg::SA_HI:0];
          next_sbhe  = REQ_BHE;
          next_state = ST_ADDR;
          load       = 1'b1;
          load_val   = imcs_pkg::ADDR_PHASE_T;
        end
      end
      ST_ADDR: begin
        if (last) begin
          next_state = ST_ALE;
          load       = 1'b1;
          load_val   = imcs_pkg::ALE_PHASE_T;
        end
      end
      ST_ALE: begin
        if (last) begin
          next_state = ST_GAP;
          load       = 1'b1;
          load_val   = imcs_pkg::GAP_PHASE_T;
        end
      end
      ST_GAP: begin
        if (last) begin
          next_state = ST_CMD;
          load       = 1'b1;
          load_val   = imcs_pkg::CMD_PHASE_T;
        end
      end
      ST_CMD: begin
        if (last) begin
          next_state = ST_HOLD;
          load       = 1'b1;
          // i/o needs the longer address hold after the command
          load_val   = (kind == imcs_pkg::KIND_IO) ? imcs_pkg::HOLD_IO_T : imcs_pkg::HOLD_MEM_T;
        end
      end
      ST_HOLD: begin
        if (last) begin
          next_state = ST_IDLE;
          next_done  = 1'b1;
        end
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
    // strobes come straight from the next state so they stay glitch free
    next_ale_n = (next_state != ST_ALE);
    next_cmd_n = (next_state == ST_CMD) ? cmd_vec(next_kind, next_write) : 6'h3f;
  end

  // register the state and every pin but REQ_READY, all frozen while the enable is low
  always_ff @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      state <= ST_IDLE;
      kind  <= imcs_pkg::KIND_MEM;
      write <= 1'b0;
      LA    <= 7'h00;
      SA    <= 20'h00000;
      SBHE  <= 1'b0;
      ALE_N <= 1'b1;
      cmd_n <= 6'h3f;
      DONE  <= 1'b0;
    end else if (CE) begin
      state <= next_state;
      kind  <= next_kind;
      write <= next_write;
      LA    <= next_la;
      SA    <= next_sa;
      SBHE  <= next_sbhe;
      ALE_N <= next_ale_n;
      cmd_n <= next_cmd_n;
      DONE  <= next_done;
    end
  end

  assign MEMR_N  = cmd_n[5];
  assign MEMW_N  = cmd_n[4];
  assign SMEMR_N = cmd_n[3];
  assign SMEMW_N = cmd_n[2];
  assign IOR_N   = cmd_n[1];
  assign IOW_N   = cmd_n[0];

  // ---- checks ----
  // tick ages since address load, latch assert, latch negate, command assert
  logic [4:0] addr_age;
  logic [4:0] ale_age;
  logic [4:0] aneg_age;
  logic [4:0] cmd_age;
  logic       last_io;
  logic       cmd_on;
  logic       cmd_on_q;
  logic       ale_q;
  logic       mem_cmd;
  logic       smem_cmd;
  logic       io_cmd;

  // saturate so long idle stretches never wrap back to small ages
  function automatic logic [4:0] age_inc(input logic [4:0] a);
    return (a == imcs_pkg::AGE_MAX) ? a : a + imcs_pkg::AGE_ONE;
  endfunction

  assign cmd_on   = (cmd_n != 6'h3f);
  assign mem_cmd  = !(MEMR_N && MEMW_N);
  assign smem_cmd = !(SMEMR_N && SMEMW_N);
  assign io_cmd   = !(IOR_N && IOW_N);

  always_ff @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      addr_age <= imcs_pkg::AGE_MAX;
      ale_age  <= imcs_pkg::AGE_MAX;
      aneg_age <= imcs_pkg::AGE_MAX;
      cmd_age  <= imcs_pkg::AGE_MAX;
      last_io  <= 1'b0;
      cmd_on_q <= 1'b0;
      ale_q    <= 1'b0;
    end else if (CE) begin
      cmd_on_q <= cmd_on;
      ale_q    <= !ALE_N;
      if (tick) begin
        addr_age <= accept ? 5'h00 : age_inc(addr_age);
        ale_age  <= (next_state == ST_ALE && state != ST_ALE) ? 5'h00 : age_inc(ale_age);
        aneg_age <= (state == ST_ALE && next_state != ST_ALE) ? 5'h00 : age_inc(aneg_age);
        cmd_age  <= (next_state == ST_CMD && state != ST_CMD) ? 5'h00 : age_inc(cmd_age);
        if (next_state == ST_CMD && state != ST_CMD) begin
          last_io <= (next_kind == imcs_pkg::KIND_IO);
        end
      end
    end
  end

  a_la_ale_neg: assert property (@(posedge CLOCK) disable iff (!RSTN)
    $rose(ALE_N) |-> addr_age >= 5'(imcs_pkg::LA_TO_ALE_NEG_T))
    else $error("LA set up too briefly before latch negation");

  a_la_mem_cmd: assert property (@(posedge CLOCK) disable iff (!RSTN)
    (mem_cmd && !cmd_on_q) |-> addr_age >= 5'(imcs_pkg::LA_TO_CMD_T))
    else $error("LA set up too briefly before memory command");

  a_sa_ale_neg: assert property (@(posedge CLOCK) disable iff (!RSTN)
    $rose(ALE_N) |-> addr_age >= 5'(imcs_pkg::SA_TO_ALE_NEG_T) && $stable(SA) && $stable(SBHE))
    else $error("SA set up too briefly before latch negation");

  a_sa_mem_cmd: assert property (@(posedge CLOCK) disable iff (!RSTN)
    (mem_cmd && !cmd_on_q) |-> addr_age >= 5'(imcs_pkg::SA_TO_CMD_T))
    else $error("SA set up too briefly before memory command");

  a_sa_smem_cmd: assert property (@(posedge CLOCK) disable iff (!RSTN)
    (smem_cmd && !cmd_on_q) |-> addr_age >= 5'(imcs_pkg::SA_TO_CMD_T))
    else $error("SA set up too briefly before low-memory command");

  a_sa_io_cmd: assert property (@(posedge CLOCK) disable iff (!RSTN)
    (io_cmd && !cmd_on_q) |-> addr_age >= 5'(imcs_pkg::SA_TO_CMD_T))
    else $error("SA set up too briefly before i/o command");

  a_ale_width: assert property (@(posedge CLOCK) disable iff (!RSTN)
    $rose(ALE_N) |-> ale_age >= 5'(imcs_pkg::ALE_WIDTH_T))
    else $error("latch strobe too short");

  a_ale_to_cmd: assert property (@(posedge CLOCK) disable iff (!RSTN)
    (cmd_on && !cmd_on_q) |-> ale_age >= 5'(imcs_pkg::ALE_TO_CMD_T))
    else $error("command too soon after latch strobe");

  a_ale_cmd_neg: assert property (@(posedge CLOCK) disable iff (!RSTN)
    (!cmd_on && cmd_on_q && !last_io) |-> ale_age >= 5'(imcs_pkg::ALE_TO_CMD_NEG_T))
    else $error("memory command negated too soon after latch");

  a_la_after_ale: assert property (@(posedge CLOCK) disable iff (!RSTN)
    $changed(LA) |-> aneg_age >= 5'(imcs_pkg::ALE_NEG_TO_LA_T))
    else $error("LA changed too soon after latch negation");

  a_mem_width: assert property (@(posedge CLOCK) disable iff (!RSTN)
    (!cmd_on && cmd_on_q && !last_io) |-> cmd_age >= 5'(imcs_pkg::CMD_WIDTH_T))
    else $error("memory command too short");

  a_io_width: assert property (@(posedge CLOCK) disable iff (!RSTN)
    (!cmd_on && cmd_on_q && last_io) |-> cmd_age >= 5'(imcs_pkg::CMD_WIDTH_T))
    else $error("i/o command too short");

  a_la_after_cmd: assert property (@(posedge CLOCK) disable iff (!RSTN)
    $changed(LA) |-> cmd_age >= 5'(imcs_pkg::CMD_TO_LA_T))
    else $error("LA changed too soon after command");

  a_sa_after_mem: assert property (@(posedge CLOCK) disable iff (!RSTN)
    ($changed(SA) && !last_io) |-> cmd_age >= 5'(imcs_pkg::CMD_TO_SA_MEM_T))
    else $error("SA changed too soon after memory command");

  a_sa_after_io: assert property (@(posedge CLOCK) disable iff (!RSTN)
    ($changed(SA) && last_io) |-> cmd_age >= 5'(imcs_pkg::CMD_TO_SA_IO_T))
    else $error("SA changed too soon after i/o command");

  a_cycle_order: assert property (@(posedge CLOCK) disable iff (!RSTN)
    (cmd_on && !cmd_on_q) |-> ALE_N && !ale_q && $stable(SA))
    else $error("command asserted out of order");

  c_mem_read: cover property (@(posedge CLOCK) disable iff (!RSTN) $fell(MEMR_N));
  c_io_write: cover property (@(posedge CLOCK) disable iff (!RSTN) $fell(IOW_N));
  c_low_mem:  cover property (@(posedge CLOCK) disable iff (!RSTN) $fell(SMEMW_N));
  c_done:     cover property (@(posedge CLOCK) disable iff (!RSTN) DONE ##[1:60] REQ_READY && REQ_VALID);
endmodule
`default_nettype wire

// File: test/imcs_slave_model.sv
// slave side model of the isa bus: watches the pins and logs event times in core cycles
`timescale 1ns/1ps
`default_nettype none
module imcs_slave_model (
  input  wire logic        clock,
  input  wire logic [6:0]  la,
  input  wire logic [19:0] sa,
  input  wire logic        sbhe,
  input  wire logic        ale_n,
  input  wire logic [5:0]  cmd_n,
  output int               now,
  output int               t_addr,
  output int               t_ale_f,
  output int               t_ale_r,
  output int               t_cmd_f,
  output int               t_cmd_r,
  output logic [5:0]       cmd_mask,
  output logic [6:0]       la_lat,
  output logic [19:0]      sa_lat,
  output logic             bhe_lat
);
  logic [27:0] prev_addr;
  logic        prev_ale;
  logic [5:0]  prev_cmd;
  logic [5:0]  cmd;

  // strobes as active-high bits, memory read in bit 0 up to i/o write in bit 5
  assign cmd = ~cmd_n;

  // every event is stamped at the edge where it is first seen, so all stamps share one offset
  always @(posedge clock) begin
    now <= now + 1;
    if ({la, sa, sbhe} !== prev_addr) begin
      t_addr <= now;
    end
    if (|cmd) begin
      cmd_mask <= cmd_mask | cmd;
    end
    if (prev_ale === 1'b1 && ale_n === 1'b0) begin
      t_ale_f  <= now;
      cmd_mask <= 6'h00;
    end
    // a slave latches the upper address on the rising latch strobe
    if (prev_ale === 1'b0 && ale_n === 1'b1) begin
      t_ale_r <= now;
      la_lat  <= la;
      sa_lat  <= sa;
      bhe_lat <= sbhe;
    end
    if (|cmd && !(|prev_cmd)) begin
      t_cmd_f <= now;
    end
    if (!(|cmd) && |prev_cmd) begin
      t_cmd_r <= now;
    end
    prev_addr <= {la, sa, sbhe};
    prev_ale  <= ale_n;
    prev_cmd  <= cmd;
  end

  // start from an idle bus so the first strobe edge is not missed
  initial begin
    now       = 0;
    prev_ale  = 1'b1;
    prev_cmd  = 6'h00;
    prev_addr = 28'h0000000;
    cmd_mask  = 6'h00;
  end
endmodule
`default_nettype wire

// File: test/isa_master_cycle_sequencer_tb.sv
// self-checking bench for the bus master cycle sequencer
`timescale 1ns/1ps
`default_nettype none
module isa_master_cycle_sequencer_tb;
  localparam int B = imcs_pkg::BCLK_CYC;
  logic        clock;
  logic        rstn;
  logic        ce;
  logic        req_valid;
  logic        req_ready;
  logic [1:0]  req_kind;
  logic        req_write;
  logic [23:0] req_addr;
  logic        req_bhe;
  logic        done;
  logic [6:0]  la;
  logic [19:0] sa;
  logic        sbhe;
  logic        ale_n;
  logic        memr_n, memw_n, smemr_n, smemw_n, ior_n, iow_n;
  int          now, t_addr, t_ale_f, t_ale_r, t_cmd_f, t_cmd_r;
  logic [5:0]  cmd_mask;
  logic [6:0]  la_lat;
  logic [19:0] sa_lat;
  logic        bhe_lat;
  int          err_total, samples_checked, last_done;

  imcs_sequencer dut (.CLOCK(clock), .RSTN(rstn), .CE(ce), .REQ_VALID(req_valid), .REQ_READY(req_ready),
    .REQ_KIND(req_kind), .REQ_WRITE(req_write), .REQ_ADDR(req_addr), .REQ_BHE(req_bhe), .DONE(done),
    .LA(la), .SA(sa), .SBHE(sbhe), .ALE_N(ale_n), .MEMR_N(memr_n), .MEMW_N(memw_n), .SMEMR_N(smemr_n),
    .SMEMW_N(smemw_n), .IOR_N(ior_n), .IOW_N(iow_n));

  imcs_slave_model slave (.clock(clock), .la(la), .sa(sa), .sbhe(sbhe), .ale_n(ale_n),
    .cmd_n({iow_n, ior_n, smemw_n, smemr_n, memw_n, memr_n}), .now(now), .t_addr(t_addr),
    .t_ale_f(t_ale_f), .t_ale_r(t_ale_r), .t_cmd_f(t_cmd_f), .t_cmd_r(t_cmd_r), .cmd_mask(cmd_mask),
    .la_lat(la_lat), .sa_lat(sa_lat), .bhe_lat(bhe_lat));

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
    samples_checked++;
    if (seen !== exp) begin
      err_total++;
      $display("CHECK FAILED t=%0t %s: seen %0h expected %0h", $time, what, seen, exp);
    end
  endtask

  task automatic wrap_up;
    $display("comparisons %0d, mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // the request is held until the edge where ready is seen high
  task automatic send(input logic [1:0] kind, input logic wr, input logic [23:0] addr, input logic bhe);
    int n;
    n = 0;
    @(posedge clock);
    #1;
    req_kind  = kind;
    req_write = wr;
    req_addr  = addr;
    req_bhe   = bhe;
    req_valid = 1'b1;
    do begin
      @(posedge clock);
      n++;
    end while (req_ready !== 1'b1 && n < 5000);
    chk(n < 5000, 1'b1, "request never taken");
    #1 req_valid = 1'b0;
  endtask

  // one whole bus cycle; fz core cycles of frozen clock enable fall inside the command
  task automatic run_one(input logic [1:0] kind, input logic wr, input logic [23:0] addr, input logic bhe,
                         input int fz);
    int n, td, io;
    logic [5:0] em;
    n = 0;
    send(kind, wr, addr, bhe);
    if (fz > 0) begin
      repeat (7 * B) @(posedge clock);
      #1 ce = 1'b0;
      repeat (fz) @(posedge clock);
      #1 ce = 1'b1;
    end
    do begin
      @(posedge clock);
      n++;
    end while (done !== 1'b1 && n < 2000);
    td = now;
    io = (kind >= 2'd2);
    em = 6'h01 << ((io ? 4 : kind * 2) + wr); // kind 3 drives the i/o strobes
    chk(n < 2000, 1'b1, "no done pulse");
    chk(cmd_mask, em, "strobe used");
    chk(t_ale_r - t_addr, 5 * B, "address to latch negation");
    chk({la_lat, sa_lat, bhe_lat}, {addr[23:17], addr[19:0], bhe}, "latched address");
    chk(t_ale_r - t_ale_f, B, "latch width");
    chk(t_cmd_f - t_ale_f, 2 * B, "latch to command");
    chk(t_cmd_f - t_addr, 6 * B, "address to command");
    chk(t_cmd_r - t_ale_f, 11 * B + fz, "latch to command negation");
    chk(t_cmd_r - t_cmd_f, 9 * B + fz, "command width");
    chk(td - t_cmd_f, (io ? 19 : 13) * B + fz, "address hold after command");
    chk(td - t_ale_r, (io ? 20 : 14) * B + fz, "upper address hold");
    if (last_done >= 0) begin
      chk(t_addr - last_done, B, "request spacing");
    end
    last_done = td;
  endtask

  // every kind and direction back to back, kind 3 included
  task automatic test_kinds;
    for (int i = 0; i < 8; i++) begin
      run_one(2'(i / 2), 1'(i % 2), 24'h812345 + 24'(i) * 24'h1a3c57, 1'(i % 2), 0);
    end
  endtask

  // a frozen clock enable stretches the command by exactly the frozen cycles
  task automatic test_freeze;
    run_one(2'd1, 1'b0, 24'h3c5a69, 1'b1, 40);
  endtask

  // reset in mid-command returns the bus to idle at once
  task automatic test_reset;
    send(2'd2, 1'b1, 24'h0f0f0f, 1'b0);
    repeat (7 * B) @(posedge clock);
    #1 rstn = 1'b0;
    repeat (3) @(posedge clock);
    chk({iow_n, ior_n, ale_n, done}, 4'he, "strobes after reset");
    chk({la, sa, sbhe}, 28'h0000000, "address after reset");
    #1 rstn = 1'b1;
    last_done = -1;
    run_one(2'd0, 1'b1, 24'hfedcba, 1'b1, 0);
  endtask

  // core clock, 5 ns period
  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end

  // watchdog sized well above the eleven bus cycles of the run, one of them cut short by reset
  initial begin
    #150000;
    err_total++;
    wrap_up();
  end

  // main sequence
  initial begin
    err_total       = 0;
    samples_checked = 0;
    last_done       = -1;
    rstn            = 1'b0;
    ce              = 1'b1;
    req_valid       = 1'b0;
    req_kind        = 2'd0;
    req_write       = 1'b0;
    req_addr        = 24'h000000;
    req_bhe         = 1'b0;
    repeat (5) @(posedge clock);
    #1 rstn = 1'b1;
    test_kinds();
    test_freeze();
    test_reset();
    wrap_up();
  end
endmodule
`default_nettype wire
